// file: aclp_ctrl.sv
// aclp_ctrl.sv: converter control with compare, low-power modes and bus slave
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module aclp_ctrl import aclp_pkg::*; (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic             wb_ack_o,
   output logic [31:0]      wb_dat_o,
   // system side
   input  wire logic        hardware_trigger_input_i,
   input  wire logic        alternate_clock_tick_i,
   input  wire logic        stop_mode_i,
   output logic             irq_o,
   output logic [15:0]      pin_analog_o,
   // analog front end
   input  wire logic [9:0]  conv_code_i,
   output logic             conv_sample_o,
   output logic [4:0]       conv_channel_o
);
   // address match, shared by write strobes and read mux
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction : hit

   aclp_cfg_t   cfg_q;
   aclp_sc1_t   sc1_q;
   aclp_sc1_t   sc1_d;
   aclp_sc1_t   new_sc1;
   aclp_sc2_t   sc2_q;
   aclp_state_t st_q;
   aclp_state_t st_d;
   logic [5:0]  cnt_q;
   logic [5:0]  cnt_d;
   logic [7:0]  cvh_q;
   logic [7:0]  cvl_q;
   logic [7:0]  pc1_q;
   logic [7:0]  pc2_q;
   logic [9:0]  result_q;
   logic [9:0]  code_q;
   logic        blk_q;
   logic        ack_q;
   logic [31:0] dat_q;
   logic        irq_q;
   logic        smp_q;
   logic [4:0]  chan_q;
   logic        trg_s1_q;
   logic        trg_s2_q;
   logic        trg_s3_q;
   logic        trg_lvl_q;

   logic        acc;
   logic        wr;
   logic        rd;
   logic        wr_sc1;
   logic        wr_sc2;
   logic        wr_cfg;
   logic        wr_cvh;
   logic        wr_cvl;
   logic        wr_pc1;
   logic        wr_pc2;
   logic        rd_rh;
   logic        rd_rl;
   logic        mode10;
   logic        stop_abort;
   logic        mode_chg;
   logic        sw_start;
   logic        trg_rise;
   logic        hw_start;
   logic        tick;
   logic        busy;
   logic        done;
   logic [9:0]  cv_full;
   logic [10:0] cv_neg;
   logic [10:0] diff;
   logic        less;
   logic        cond;
   logic        blocked;
   logic        xfer_ok;
   logic        again;
   logic        set_conversion_complete_flag;
   logic        clr_conversion_complete_flag;
   logic [5:0]  smp_len;
   logic [5:0]  apx_len;
   logic [7:0]  rd_byte;

   // bus strobes act at the edge where the master sees ack
   assign acc    = wb_cyc_i && wb_stb_i && ack_q;
   assign wr     = acc && wb_we_i && wb_sel_i[0];
   assign rd     = acc && !wb_we_i;
   assign wr_sc1 = wr && hit(wb_adr_i, ADR_SC1);
   assign wr_sc2 = wr && hit(wb_adr_i, ADR_SC2);
   assign wr_cfg = wr && hit(wb_adr_i, ADR_CFG);
   assign wr_cvh = wr && hit(wb_adr_i, ADR_CVH);
   assign wr_cvl = wr && hit(wb_adr_i, ADR_CVL);
   assign wr_pc1 = wr && hit(wb_adr_i, ADR_PC1);
   assign wr_pc2 = wr && hit(wb_adr_i, ADR_PC2);
   assign rd_rh  = rd && hit(wb_adr_i, ADR_RH);
   assign rd_rl  = rd && hit(wb_adr_i, ADR_RL);

   // mode and control decode
   assign new_sc1    = aclp_sc1_t'(wb_dat_i[7:0]);
   assign mode10     = cfg_q.mode == MODE_10;
   assign busy       = st_q != ST_IDLE;
   assign done       = st_q == ST_DONE;
   // async clock keeps running in stop; any other source is lost there
   assign stop_abort = stop_mode_i && (cfg_q.clk_sel != CLK_ASYNC);
   assign mode_chg   = wr_sc2 || wr_cfg || wr_cvh || wr_cvl;
   assign sw_start   = wr_sc1 && (new_sc1.ch != CH_OFF) && !sc2_q.trg;
   // wait mode gates nothing, so triggers and continuous runs go on
   assign hw_start   = sc2_q.trg && trg_rise && !busy
                       && (sc1_q.ch != CH_OFF);
   assign smp_len    = cfg_q.lsmp ? SMP_LONG : SMP_SHORT;
   assign apx_len    = mode10 ? APX_10 : APX_8;

   // trigger pin: three flops, level changes once stages two and three agree
   assign trg_rise = (trg_s2_q == trg_s3_q) && trg_s3_q && !trg_lvl_q;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         trg_s1_q  <= 1'b0;
         trg_s2_q  <= 1'b0;
         trg_s3_q  <= 1'b0;
         trg_lvl_q <= 1'b0;
      end else begin
         trg_s1_q  <= hardware_trigger_input_i;
         trg_s2_q  <= trg_s1_q;
         trg_s3_q  <= trg_s2_q;
         trg_lvl_q <= (trg_s2_q == trg_s3_q) ? trg_s3_q : trg_lvl_q;
      end
   end

   // conversion clock enable
   aclp_clkdiv u_clkdiv (
      .clk_i      (clk_i),
      .rst_b_i    (rst_b_i),
      .clk_sel_i  (cfg_q.clk_sel),
      .div_sel_i  (cfg_q.div),
      .alt_tick_i (alternate_clock_tick_i),
      .run_i      (st_q == ST_SAMPLE || st_q == ST_APPROX),
      .tick_o     (tick)
   );

   // compare arithmetic; eight-bit mode uses the low compare byte only
   assign cv_full = mode10 ? {cvh_q[1:0], cvl_q} : {2'h0, cvl_q};
   assign cv_neg  = 11'(~{1'b0, cv_full} + 11'h001);
   assign diff    = 11'({1'b0, code_q} + cv_neg);
   assign less    = diff[10];
   assign cond    = sc2_q.compare_greater_select ? !less : less;
   // blocking only exists in ten-bit mode
   assign blocked = blk_q && mode10;
   assign xfer_ok = !blocked && (!sc2_q.compare_function_enable || cond);
   // a blocked result retries, except a failed single compare
   assign again   = blocked ? !(sc2_q.compare_function_enable && !cond && !sc1_q.cont)
                            : sc1_q.cont;
   assign set_conversion_complete_flag = done && xfer_ok && !stop_abort;
   assign clr_conversion_complete_flag = wr_sc1 || rd_rl;

   // sequencer: a running conversion is left alone by wait mode
   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      case (st_q)
         ST_IDLE: begin
            if (hw_start) begin
               st_d  = ST_SAMPLE;
               cnt_d = smp_len;
            end
         end
         ST_SAMPLE: begin
            if (tick) begin
               st_d  = (cnt_q == 6'h01) ? ST_APPROX : ST_SAMPLE;
               cnt_d = (cnt_q == 6'h01) ? apx_len : 6'(cnt_q - 6'h01);
            end
         end
         ST_APPROX: begin
            if (tick) begin
               st_d  = (cnt_q == 6'h01) ? ST_DONE : ST_APPROX;
               cnt_d = 6'(cnt_q - 6'h01);
            end
         end
         ST_DONE: begin
            st_d  = again ? ST_SAMPLE : ST_IDLE;
            cnt_d = smp_len;
         end
         default: st_d = ST_IDLE;
      endcase
      if (sw_start) begin
         st_d  = ST_SAMPLE;
         cnt_d = smp_len;
      end else if (mode_chg || wr_sc1) begin
         st_d = ST_IDLE;
      end
      if (stop_abort) begin
         st_d = ST_IDLE;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_q  <= ST_IDLE;
         cnt_q <= 6'h00;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // code taken from the front end as approximation ends
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         code_q <= 10'h000;
      end else if (st_q == ST_APPROX && st_d == ST_DONE) begin
         code_q <= mode10 ? conv_code_i : {2'h0, conv_code_i[9:2]};
      end
   end

   // result transfer; stop never touches it, but a register write abort in the done cycle still transfers
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         result_q <= 10'h000;
      end else if (set_conversion_complete_flag) begin
         result_q <= sc2_q.compare_function_enable ? diff[9:0] : code_q;
      end
   end

   // first control; completion flag set wins over any clear
   always_comb begin
      sc1_d = sc1_q;
      if (wr_sc1) begin
         sc1_d = new_sc1;
      end
      if (clr_conversion_complete_flag) begin
         sc1_d.conversion_complete_flag = 1'b0;
      end
      if (set_conversion_complete_flag) begin
         sc1_d.conversion_complete_flag = 1'b1;
      end
   end

   // control registers
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sc1_q <= aclp_sc1_t'(SC1_RST);
         sc2_q <= aclp_sc2_t'(REG_RST);
         cfg_q <= aclp_cfg_t'(REG_RST);
         cvh_q <= REG_RST;
         cvl_q <= REG_RST;
         pc1_q <= REG_RST;
         pc2_q <= REG_RST;
      end else begin
         sc1_q <= sc1_d;
         if (wr_sc2) begin
            sc2_q <= {1'b0, wb_dat_i[6:4], 4'h0};
         end
         if (wr_cfg) begin
            cfg_q <= aclp_cfg_t'(wb_dat_i[7:0]);
         end
         if (wr_cvh) begin
            cvh_q <= wb_dat_i[7:0];
         end
         if (wr_cvl) begin
            cvl_q <= wb_dat_i[7:0];
         end
         if (wr_pc1) begin
            pc1_q <= wb_dat_i[7:0];
         end
         if (wr_pc2) begin
            pc2_q <= wb_dat_i[7:0];
         end
      end
   end

   // read blocking: high byte read opens, low byte read closes
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         blk_q <= 1'b0;
      end else if (rd_rh && mode10) begin
         blk_q <= 1'b1;
      end else if (rd_rl) begin
         blk_q <= 1'b0;
      end
   end

   // read mux; unmapped addresses read zero
   assign rd_byte =
      hit(wb_adr_i, ADR_SC1) ? sc1_q :
      hit(wb_adr_i, ADR_SC2) ? {busy, sc2_q.trg, sc2_q.compare_function_enable, sc2_q.compare_greater_select, 4'h0} :
      hit(wb_adr_i, ADR_CFG) ? cfg_q :
      hit(wb_adr_i, ADR_RH)  ? {6'h00, result_q[9:8]} :
      hit(wb_adr_i, ADR_RL)  ? result_q[7:0] :
      hit(wb_adr_i, ADR_CVH) ? cvh_q :
      hit(wb_adr_i, ADR_CVL) ? cvl_q :
      hit(wb_adr_i, ADR_PC1) ? pc1_q :
      hit(wb_adr_i, ADR_PC2) ? pc2_q : 8'h00;

   // one wait state; ack drops the cycle after it was given
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
         if (wb_cyc_i && wb_stb_i && !ack_q) begin
            dat_q <= {24'h00_0000, rd_byte};
         end
      end
   end

   // outputs, each from a flop; irq lags the flag by one cycle
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_q  <= 1'b0;
         smp_q  <= 1'b0;
         chan_q <= CH_OFF;
      end else begin
         irq_q  <= sc1_q.conversion_complete_flag && sc1_q.ien;
         smp_q  <= st_d == ST_SAMPLE;
         chan_q <= sc1_d.ch;
      end
   end

   assign wb_ack_o       = ack_q;
   assign wb_dat_o       = dat_q;
   assign irq_o          = irq_q;
   assign conv_sample_o  = smp_q;
   assign conv_channel_o = chan_q;
   assign pin_analog_o   = {pc2_q, pc1_q};

   // checks
   sequence s_done_fail;
      done && !xfer_ok;
   endsequence

   sequence s_sw_launch;
      sw_start && !stop_abort ##1 st_q == ST_SAMPLE;
   endsequence

   AST_IRQ_FOLLOWS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      set_conversion_complete_flag && sc1_q.ien && !clr_conversion_complete_flag |=> ##1 irq_o)
      else $error("irq not raised after flag set");
   AST_FAIL_NO_FLAG: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_done_fail |=> !$rose(sc1_q.conversion_complete_flag))
      else $error("flag set on failed transfer");
   AST_FAIL_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_done_fail |=> $stable(result_q))
      else $error("result changed on failed transfer");
   AST_DIFF_LOAD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      set_conversion_complete_flag && sc2_q.compare_function_enable |=> result_q == $past(diff[9:0]))
      else $error("result is not the compare difference");
   AST_GE_SET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      done && sc2_q.compare_function_enable && sc2_q.compare_greater_select && !blocked |-> (xfer_ok == (code_q >= cv_full)))
      else $error("greater or equal compare wrong");
   AST_LT_SET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      done && sc2_q.compare_function_enable && !sc2_q.compare_greater_select && !blocked |-> (xfer_ok == (code_q < cv_full)))
      else $error("less than compare wrong");
   AST_STOP_IDLE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      stop_abort |=> st_q == ST_IDLE && $stable(result_q))
      else $error("stop did not abort to idle");
   AST_MODE_ABORT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      mode_chg && !sw_start |=> st_q == ST_IDLE)
      else $error("mode change did not abort");
   AST_SW_START: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      sw_start && !stop_abort |-> s_sw_launch)
      else $error("software write did not start conversion");
endmodule : aclp_ctrl

// file: aclp_pkg.sv
// aclp_pkg.sv: constants and types shared by the converter control
package aclp_pkg;
   // register byte addresses, one aligned word each
   localparam logic [7:0] ADR_SC1 = 8'h00;
   localparam logic [7:0] ADR_SC2 = 8'h04;
   localparam logic [7:0] ADR_CFG = 8'h08;
   localparam logic [7:0] ADR_RH  = 8'h0C;
   localparam logic [7:0] ADR_RL  = 8'h10;
   localparam logic [7:0] ADR_CVH = 8'h14;
   localparam logic [7:0] ADR_CVL = 8'h18;
   localparam logic [7:0] ADR_PC1 = 8'h1C;
   localparam logic [7:0] ADR_PC2 = 8'h20;

   // reset values
   localparam logic [7:0] SC1_RST = 8'h1F;
   localparam logic [7:0] REG_RST = 8'h00;

   // field encodings
   localparam logic [4:0] CH_OFF    = 5'h1F;
   localparam logic [1:0] MODE_10   = 2'h2;
   localparam logic [1:0] CLK_BUS   = 2'h0;
   localparam logic [1:0] CLK_HALF  = 2'h1;
   localparam logic [1:0] CLK_ALT   = 2'h2;
   localparam logic [1:0] CLK_ASYNC = 2'h3;

   // conversion clock counts per phase
   localparam logic [5:0] SMP_SHORT = 6'h04;
   localparam logic [5:0] SMP_LONG  = 6'h18;
   localparam logic [5:0] APX_10    = 6'h13;
   localparam logic [5:0] APX_8     = 6'h10;

   // internal asynchronous conversion clock period
   localparam int CLK_PERIOD_NS   = 100;
   localparam int ASYNC_PERIOD_NS = 500;
   localparam int ASYNC_DIV_CYC   =
      (ASYNC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] ASYNC_LAST = 3'(ASYNC_DIV_CYC - 1);

   // register layouts
   typedef struct packed {
      logic       lp;
      logic [1:0] div;
      logic       lsmp;
      logic [1:0] mode;
      logic [1:0] clk_sel;
   } aclp_cfg_t;

   typedef struct packed {
      logic       conversion_complete_flag;
      logic       ien;
      logic       cont;
      logic [4:0] ch;
   } aclp_sc1_t;

   typedef struct packed {
      logic       act;
      logic       trg;
      logic       compare_function_enable;
      logic       compare_greater_select;
      logic [3:0] rsv;
   } aclp_sc2_t;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_SAMPLE = 4'b0010,
      ST_APPROX = 4'b0100,
      ST_DONE   = 4'b1000
   } aclp_state_t;
endpackage : aclp_pkg

// file: aclp_clkdiv.sv
// aclp_clkdiv.sv: conversion clock enable from source select and divider
`timescale 1ns/1ps
module aclp_clkdiv import aclp_pkg::*; (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // selection
   input  wire logic [1:0] clk_sel_i,
   input  wire logic [1:0] div_sel_i,
   input  wire logic       alt_tick_i,
   input  wire logic       run_i,
   // conversion clock enable
   output logic            tick_o
);
   logic       half_q;
   logic [2:0] acnt_q;
   logic [2:0] dcnt_q;
   logic       async_tick;
   logic       base_tick;
   logic [2:0] div_mask;

   // async generator only runs while converting, like a gated oscillator
   assign async_tick = run_i && (acnt_q == ASYNC_LAST);
   // all four sources stay usable in wait mode
   assign base_tick = (clk_sel_i == CLK_BUS)  ? 1'b1 :
                      (clk_sel_i == CLK_HALF) ? half_q :
                      (clk_sel_i == CLK_ALT)  ? alt_tick_i : async_tick;
   // divide by 1, 2, 4 or 8
   assign div_mask = 3'((4'h1 << div_sel_i) - 4'h1);
   assign tick_o   = run_i && base_tick && ((dcnt_q & div_mask) == div_mask);

   // counters restart with each conversion so phases start aligned
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         half_q <= 1'b0;
         acnt_q <= 3'h0;
         dcnt_q <= 3'h0;
      end else begin
         half_q <= !half_q;
         acnt_q <= (!run_i || async_tick) ? 3'h0 : 3'(acnt_q + 3'h1);
         dcnt_q <= !run_i ? 3'h0 : (base_tick ? 3'(dcnt_q + 3'h1) : dcnt_q);
      end
   end
endmodule : aclp_clkdiv

// file: aclp_afe_model.sv
// aclp_afe_model.sv: behavioural analog front end feeding codes
`timescale 1ns/1ps
module aclp_afe_model (
   // clock
   input  wire logic       clk_i,
   // converter side
   input  wire logic       sample_i,
   input  wire logic [4:0] channel_i,
   // level presented by the bench
   input  wire logic [9:0] level_i,
   output logic [9:0]      code_o
);
   // track while sampling, then hold like the sample capacitor
   // other channels see the inverse, so a wrong channel shows up
   always_ff @(posedge clk_i) begin
      if (sample_i) begin
         code_o <= (channel_i == 5'h01) ? level_i : ~level_i;
      end
   end
endmodule : aclp_afe_model

// file: aclp_ctrl_tb.sv
// aclp_ctrl_tb.sv: register-level tests of the converter control
`timescale 1ns/1ps
module aclp_ctrl_tb import aclp_pkg::*; ;
   logic        clk_i, rst_b_i, cyc, stb, we, trig, alt, stop, ack, irq, smp;
   logic [7:0]  adr;
   logic [3:0]  sel, sel_v;
   logic [31:0] dat, dato, rdv;
   logic [15:0] pins;
   logic [9:0]  code, level, res;
   logic [4:0]  chn;
   int          errors, tests_run;
   // compare cases: limit 0x100, both sides and the equal boundary
   logic [7:0]  t_sc2 [5] = '{8'h30, 8'h30, 8'h30, 8'h20, 8'h20};
   logic [9:0]  t_lvl [5] = '{10'h2A5, 10'h100, 10'h0FF, 10'h0FF, 10'h100};
   logic        t_hit [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

   // 100 ns clock, alternate source ticking every other cycle
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) alt <= ~alt;

   aclp_ctrl u_dut (
      .clk_i(clk_i), .rst_b_i(rst_b_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(dato),
      .hardware_trigger_input_i(trig), .alternate_clock_tick_i(alt),
      .stop_mode_i(stop), .irq_o(irq), .pin_analog_o(pins),
      .conv_code_i(code), .conv_sample_o(smp), .conv_channel_o(chn)
   );

   aclp_afe_model u_afe (
      .clk_i(clk_i), .sample_i(smp), .channel_i(chn),
      .level_i(level), .code_o(code)
   );

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // classic cycle: hold the request until ack is seen at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= sel_v;
      dat <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rdv = dato;
      if (n >= 20) begin
         chk({31'h0, ack}, 32'h1);
      end
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      chk(rdv, {24'h0, e});
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
   endtask : settle

   // trigger held for three cycles so the synchroniser cannot miss it
   task automatic hw_pulse();
      trig <= 1'b1;
      repeat (3) @(posedge clk_i);
      trig <= 1'b0;
   endtask : hw_pulse

   task automatic close_out();
      $display("counts: %0d checks, %0d mismatches", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   // watchdog well beyond the few thousand cycles the tests need
   initial begin
      #2_000_000;
      errors++;
      close_out();
   end

   initial begin
      clk_i = 1'b0;
      rst_b_i = 1'b0;
      {cyc, stb, we, trig, alt, stop} = 6'h00;
      adr = 8'h00;
      sel = 4'h0;
      sel_v = 4'hF;
      dat = 32'h0;
      level = 10'h000;
      res = 10'h000;
      errors = 0;
      tests_run = 0;
      repeat (16) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd(ADR_SC1, SC1_RST);
      rd(ADR_SC2, 8'h00);
      rd(ADR_CFG, 8'h00);
      wr(ADR_CFG, 8'h98);
      rd(ADR_CFG, 8'h98);
      sel_v = 4'hE;
      wr(ADR_CFG, 8'h00);
      sel_v = 4'hF;
      rd(ADR_CFG, 8'h98);
      wr(ADR_SC2, 8'h3C);
      rd(ADR_SC2, 8'h30);
      wr(8'h24, 8'hFF);
      rd(8'h24, 8'h00);
      wr(ADR_PC1, 8'h02);
      settle(1);
      chk({16'h0, pins}, 32'h0002);
      wr(ADR_CVH, 8'h01);
      wr(ADR_CVL, 8'h00);
      rd(ADR_CVH, 8'h01);
      wr(ADR_CFG, 8'h08);
      $display("test registers done");
      // compare both ways; misses must leave flag and results alone
      for (int i = 0; i < 5; i++) begin
         wr(ADR_SC2, t_sc2[i]);
         level <= t_lvl[i];
         wr(ADR_SC1, 8'h41);
         settle(60);
         if (t_hit[i]) begin
            res = t_lvl[i] - 10'h100;
         end
         chk({31'h0, irq}, {31'h0, t_hit[i]});
         rd(ADR_SC1, {t_hit[i], 7'h41});
         rd(ADR_RH, {6'h0, res[9:8]});
         rd(ADR_RL, res[7:0]);
      end
      wr(ADR_SC2, 8'h00);
      $display("test compare done");
      // high byte read holds off the next result until the low byte
      level <= 10'h2AA;
      wr(ADR_SC1, 8'h41);
      settle(60);
      rd(ADR_RH, 8'h02);
      level <= 10'h111;
      wr(ADR_SC1, 8'h41);
      settle(60);
      rd(ADR_SC1, 8'h41);
      rd(ADR_RL, 8'hAA);
      settle(60);
      rd(ADR_RH, 8'h01);
      rd(ADR_RL, 8'h11);
      $display("test blocking done");
      level <= 10'h0F0;
      wr(ADR_SC1, 8'h41);
      wr(ADR_CVL, 8'h00);
      settle(60);
      rd(ADR_SC1, 8'h41);
      $display("test write abort done");
      // stop on the bus clock aborts and stays idle afterwards
      level <= 10'h3C3;
      wr(ADR_SC1, 8'h41);
      rd(ADR_SC2, 8'h80);
      stop <= 1'b1;
      settle(60);
      rd(ADR_SC1, 8'h41);
      rd(ADR_RH, 8'h01);
      rd(ADR_RL, 8'h11);
      stop <= 1'b0;
      settle(60);
      rd(ADR_SC2, 8'h00);
      wr(ADR_SC2, 8'h40);
      hw_pulse();
      settle(60);
      chk({31'h0, irq}, 32'h1);
      rd(ADR_RH, 8'h03);
      rd(ADR_RL, 8'hC3);
      $display("test stop abort done");
      // async clock keeps converting through stop and wakes by irq
      wr(ADR_CFG, 8'h0B);
      level <= 10'h155;
      hw_pulse();
      stop <= 1'b1;
      settle(250);
      chk({31'h0, irq}, 32'h1);
      rd(ADR_RH, 8'h01);
      rd(ADR_RL, 8'h55);
      stop <= 1'b0;
      $display("test async stop done");
      // continuous runs on half bus clock divided by two, long sample
      wr(ADR_SC2, 8'h00);
      wr(ADR_CFG, 8'h39);
      level <= 10'h2C4;
      wr(ADR_SC1, 8'h61);
      settle(300);
      chk({31'h0, irq}, 32'h1);
      rd(ADR_RH, 8'h02);
      rd(ADR_RL, 8'hC4);
      level <= 10'h0AA;
      settle(300);
      rd(ADR_SC1, 8'hE1);
      rd(ADR_RH, 8'h00);
      rd(ADR_RL, 8'hAA);
      wr(ADR_SC1, 8'h1F);
      rd(ADR_SC2, 8'h00);
      $display("test continuous done");
      close_out();
   end
endmodule : aclp_ctrl_tb
